// file: hw/rtxcrb_bank.sv
// Serial-loaded control register bank for the transmitter front end.
// Assumes the host drives serial clock, data and latch enable slowly
// against clk_in; all three pins are resynchronised here.

`timescale 1ns/1ps

module rtxcrb_bank #(
  parameter int WORD_W = 32
) (
  // Clock and reset
  input  wire  logic                         clk_in,
  input  wire  logic                         rst_in,
  // Serial programming pins
  input  wire  rtxcrb_pkg::rtxcrb_serial_type serial_in,
  // Control outputs
  output       rtxcrb_pkg::rtxcrb_ctrl_type   ctrl_out,
  output       logic                         conv_start_out,
  // Word status
  output       logic                         word_taken_out,
  output       logic                         word_refused_out
);
  import rtxcrb_pkg::*;

  localparam int CNT_W = $clog2(WORD_W + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(WORD_W);
  localparam int PIN_N = 3;
  localparam int PIN_CLK = 0;
  localparam int PIN_DAT = 1;
  localparam int PIN_LE  = 2;

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (WORD_W != 32) begin : g_bad_width
    $error("rtxcrb_bank: WORD_W must be 32");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync1;
  logic [PIN_N-1:0] sync2;
  logic [PIN_N-1:0] sync3;
  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_rise;

  assign pin_raw = serial_in;

  // Three stages; a clock or latch level counts only once stages two and three agree, data is read straight from stage three
  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        sync1[i]   <= 1'b0;
        sync2[i]   <= 1'b0;
        sync3[i]   <= 1'b0;
        pin_lvl[i] <= 1'b0;
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          pin_lvl[i] <= sync3[i];
        end
      end
    end
    // Rising edge of the filtered level, seen once
    assign pin_rise[i] = (sync2[i] == sync3[i]) && sync3[i] && !pin_lvl[i];
  end

  logic clk_rise;
  logic le_rise;
  logic data_lvl;

  assign clk_rise = pin_rise[PIN_CLK];
  assign le_rise  = pin_rise[PIN_LE];
  assign data_lvl = sync3[PIN_DAT];

  // ------------------------------------------------------------
  // Frame state machine
  // ------------------------------------------------------------
  rtxcrb_state_type state;
  rtxcrb_state_type next_state;

  // Next frame state; a latch always ends the frame, whatever the count
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (le_rise) begin
          next_state = ST_LOAD;
        end else if (clk_rise) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (le_rise) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Shift register and bit count
  // ------------------------------------------------------------
  logic [WORD_W-1:0] shreg;
  logic [CNT_W-1:0]  bit_cnt;
  logic              shift_en;

  // Clock edges during the load cycle are dropped so the word holds still
  assign shift_en = clk_rise && (state != ST_LOAD);

  // MSB enters first and ends at the top after the last bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shreg <= '0;
    end else if (shift_en) begin
      shreg <= {shreg[WORD_W-2:0], data_lvl};
    end
  end

  // Count saturates; extra leading bits simply fall off the top
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bit_cnt <= '0;
    end else if (state == ST_LOAD) begin
      bit_cnt <= '0;
    end else if (shift_en && bit_cnt != FULL_COUNT) begin
      bit_cnt <= bit_cnt + CNT_W'(1);
    end
  end

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic [SEL_W-1:0] sel;
  logic             full;
  logic             mapped;
  logic             load_ok;

  // Select code sits in the last five bits shifted in
  assign sel  = shreg[SEL_W-1:0];
  assign full = (bit_cnt == FULL_COUNT);

  // Codes 6 to 10 and above 11 belong to blocks outside this bank
  always_comb begin
    case (sel)
      SEL_PWR, SEL_TXREF, SEL_CONV, SEL_OUTSEL,
      SEL_TEST, SEL_DIV, SEL_CNTRST: mapped = 1'b1;
      default:                       mapped = 1'b0;
    endcase
  end

  // Short words are refused so a glitched frame cannot retune the part
  assign load_ok = (state == ST_LOAD) && full && mapped;

  // ------------------------------------------------------------
  // Double buffered converter clock divider
  // ------------------------------------------------------------
  logic [7:0] pend_clk_div;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pend_clk_div <= '0;
    end else if (load_ok && sel == SEL_CONV) begin
      pend_clk_div <= shreg[CDIV_HI:CDIV_LO];
    end
  end

  // ------------------------------------------------------------
  // Control register file
  // ------------------------------------------------------------
  // Both transmit power bits are stored as written; exclusivity is the host's
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_out <= CTRL_RESET;
    end else if (load_ok) begin
      case (sel)
        SEL_PWR: begin
          ctrl_out.aux_gain                    <= shreg[AUX_GAIN_HI:AUX_GAIN_LO];
          ctrl_out.aux_div_one                 <= shreg[AUX_DIV_BIT];
          ctrl_out.ref_cnt_pwr                 <= shreg[REF_PWR_BIT];
          ctrl_out.fb_cnt_pwr                  <= shreg[FB_PWR_BIT];
          ctrl_out.cal_second_tx               <= shreg[CAL2_BIT];
          ctrl_out.cal_first_tx                <= shreg[CAL1_BIT];
          ctrl_out.osc_pwr                     <= shreg[OSC_PWR_BIT];
          ctrl_out.osc_cal                     <= shreg[OSC_CAL_BIT];
          ctrl_out.conv_pwr                    <= shreg[CONV_PWR_BIT];
          ctrl_out.second_transmit_channel_pwr <= shreg[TX2_PWR_BIT];
          ctrl_out.first_transmit_channel_pwr  <= shreg[TX1_PWR_BIT];
          ctrl_out.mixer_drive_output_pwr      <= shreg[MIX_PWR_BIT];
        end
        SEL_TXREF: begin
          ctrl_out.tx_level_code <= shreg[LVL_HI:LVL_LO];
        end
        SEL_CONV: begin
          ctrl_out.conv_avg <= shreg[AVG_HI:AVG_LO];
        end
        SEL_OUTSEL: begin
          ctrl_out.mux_sel       <= shreg[MUX_HI:MUX_LO];
          ctrl_out.io_level_high <= shreg[IOLVL_BIT];
          ctrl_out.readback_sel  <= shreg[RDBK_HI:RDBK_LO];
        end
        SEL_TEST: begin
          ctrl_out.mux_normal    <= shreg[MUXN_BIT];
          ctrl_out.test_to_conv  <= shreg[TCONV_BIT];
          ctrl_out.test_to_probe <= shreg[TPROBE_BIT];
          ctrl_out.test_sel      <= shreg[TSEL_HI:TSEL_LO];
        end
        SEL_DIV: begin
          ctrl_out.int_divide                <= shreg[INT_HI:INT_LO];
          ctrl_out.sub_unit_divide_value_msb <= shreg[SUB_UNIT_DIVIDE_VALUE_HI:SUB_UNIT_DIVIDE_VALUE_LO];
          ctrl_out.conv_clk_div              <= pend_clk_div;
        end
        SEL_CNTRST: begin
          ctrl_out.counter_reset_flag <= shreg[CRST_BIT];
        end
        default: begin
          ctrl_out.counter_reset_flag <= ctrl_out.counter_reset_flag;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pulses
  // ------------------------------------------------------------
  // Start is a one-shot; the stored bit would otherwise retrigger nothing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= load_ok && (sel == SEL_CONV) && shreg[START_BIT];
    end
  end

  // Word status pulses; a refused word leaves every control output as it was
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_taken_out   <= 1'b0;
      word_refused_out <= 1'b0;
    end else begin
      word_taken_out   <= load_ok;
      word_refused_out <= (state == ST_LOAD) && !load_ok;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // All checks run on clk_in and rest while reset is held
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_unmapped_ignored: assert property (
    (state == ST_LOAD) && !mapped |=> $stable(ctrl_out) && !word_taken_out)
    else $error("unmapped code changed the bank");

  chk_aux_gain_field: assert property (
    load_ok && sel == SEL_PWR |=> ctrl_out.aux_gain == $past(shreg[23:21]))
    else $error("aux gain not loaded from bits 23..21");

  chk_aux_div_pick: assert property (
    load_ok && sel == SEL_PWR |=> ctrl_out.aux_div_one == $past(shreg[20]))
    else $error("aux divider not loaded from bit 20");

  chk_counter_power: assert property (
    load_ok && sel == SEL_PWR |=>
      {ctrl_out.ref_cnt_pwr, ctrl_out.fb_cnt_pwr} == $past(shreg[15:14]))
    else $error("counter power bits wrong");

  chk_amp_cal: assert property (
    load_ok && sel == SEL_PWR |=>
      {ctrl_out.cal_second_tx, ctrl_out.cal_first_tx} == $past(shreg[12:11]))
    else $error("calibration requests wrong");

  chk_osc_bits: assert property (
    load_ok && sel == SEL_PWR |=>
      {ctrl_out.osc_pwr, ctrl_out.osc_cal, ctrl_out.conv_pwr} == $past(shreg[10:8]))
    else $error("oscillator or converter bits wrong");

  chk_tx_power: assert property (
    load_ok && sel == SEL_PWR |=>
      {ctrl_out.second_transmit_channel_pwr, ctrl_out.first_transmit_channel_pwr,
       ctrl_out.mixer_drive_output_pwr} == $past(shreg[7:5]))
    else $error("transmit or mixer power bits wrong");

  chk_level_code: assert property (
    load_ok && sel == SEL_TXREF |=> ctrl_out.tx_level_code == $past(shreg[12:5]))
    else $error("level code not loaded");

  chk_start_pulse: assert property (
    conv_start_out |-> $past(load_ok && sel == SEL_CONV && shreg[15]) ##1 !conv_start_out)
    else $error("conversion start not a single qualified pulse");

  chk_avg_field: assert property (
    load_ok && sel == SEL_CONV |=> ctrl_out.conv_avg == $past(shreg[14:13])
      && $stable(ctrl_out.conv_clk_div))
    else $error("average loaded wrong or divider not buffered");

  chk_outsel_fields: assert property (
    load_ok && sel == SEL_OUTSEL |=>
      ctrl_out.mux_sel == $past(shreg[15:12]) && ctrl_out.readback_sel == $past(shreg[10:5]))
    else $error("output select fields wrong");

  chk_test_route: assert property (
    load_ok && sel == SEL_TEST |=> ctrl_out.mux_normal == $past(shreg[21])
      && {ctrl_out.test_to_conv, ctrl_out.test_to_probe, ctrl_out.test_sel}
         == $past(shreg[16:5]))
    else $error("test routing fields wrong");

  chk_divide_transfer: assert property (
    load_ok && sel == SEL_DIV |=> ctrl_out.conv_clk_div == $past(pend_clk_div)
      && ctrl_out.int_divide == $past(shreg[28:17])
      && ctrl_out.sub_unit_divide_value_msb == $past(shreg[16:5]))
    else $error("register 5 write did not transfer fields");

  chk_counter_reset: assert property (
    load_ok && sel == SEL_CNTRST |=> ctrl_out.counter_reset_flag == $past(shreg[5]))
    else $error("counter reset flag not loaded");

  chk_latch_only: assert property (
    !load_ok |=> $stable(ctrl_out))
    else $error("bank changed without a latched word");

  chk_latch_reach: assert property (
    le_rise && full && mapped && state != ST_LOAD |-> ##2 word_taken_out)
    else $error("latched full word not taken in two cycles");

  // Frame handling: buffering, bit order, short words and stray latches
  chk_pend_capture: assert property (
    load_ok && sel == SEL_CONV |=> pend_clk_div == $past(shreg[12:5]))
    else $error("converter divider not buffered from bits 12..5");

  chk_shift_order: assert property (
    shift_en |=> shreg[0] == $past(data_lvl) && shreg[WORD_W-1:1] == $past(shreg[WORD_W-2:0]))
    else $error("serial bit not shifted in at the bottom");

  chk_short_refused: assert property (
    (state == ST_LOAD) && !full |=> word_refused_out && !word_taken_out && $stable(ctrl_out))
    else $error("short word not refused");

  chk_idle_latch: assert property (
    le_rise && state == ST_IDLE |-> ##2 word_refused_out)
    else $error("latch without clocked bits not refused");

  chk_start_with_word: assert property (
    conv_start_out |-> word_taken_out)
    else $error("conversion start without a taken word");

  // Main scenarios the bench should reach
  cov_power_write:  cover property (load_ok && sel == SEL_PWR);
  cov_conv_start:   cover property (conv_start_out);
  cov_divide_write: cover property (load_ok && sel == SEL_CONV ##[1:1000] load_ok && sel == SEL_DIV);
  cov_short_word:   cover property (word_refused_out);
  cov_idle_latch:   cover property (le_rise && state == ST_IDLE);

endmodule

// file: hw/rtxcrb_pkg.sv
// Constants, field layouts and carrier types for the transmitter control bank.
// Assumes a single 50 MHz system clock; the serial pins arrive unsynchronised.

package rtxcrb_pkg;

  // ------------------------------------------------------------
  // Register select codes
  // ------------------------------------------------------------
  localparam int          SEL_W      = 5;
  localparam logic [4:0]  SEL_PWR    = 5'h00;
  localparam logic [4:0]  SEL_TXREF  = 5'h01;
  localparam logic [4:0]  SEL_CONV   = 5'h02;
  localparam logic [4:0]  SEL_OUTSEL = 5'h03;
  localparam logic [4:0]  SEL_TEST   = 5'h04;
  localparam logic [4:0]  SEL_DIV    = 5'h05;
  localparam logic [4:0]  SEL_CNTRST = 5'h0B;

  // ------------------------------------------------------------
  // Field positions (bit numbers within the 32-bit word)
  // ------------------------------------------------------------
  localparam int AUX_GAIN_HI  = 23;
  localparam int AUX_GAIN_LO  = 21;
  localparam int AUX_DIV_BIT  = 20;
  localparam int REF_PWR_BIT  = 15;
  localparam int FB_PWR_BIT   = 14;
  localparam int CAL2_BIT     = 12;
  localparam int CAL1_BIT     = 11;
  localparam int OSC_PWR_BIT  = 10;
  localparam int OSC_CAL_BIT  = 9;
  localparam int CONV_PWR_BIT = 8;
  localparam int TX2_PWR_BIT  = 7;
  localparam int TX1_PWR_BIT  = 6;
  localparam int MIX_PWR_BIT  = 5;
  localparam int LVL_HI       = 12;
  localparam int LVL_LO       = 5;
  localparam int START_BIT    = 15;
  localparam int AVG_HI       = 14;
  localparam int AVG_LO       = 13;
  localparam int CDIV_HI      = 12;
  localparam int CDIV_LO      = 5;
  localparam int MUX_HI       = 15;
  localparam int MUX_LO       = 12;
  localparam int IOLVL_BIT    = 11;
  localparam int RDBK_HI      = 10;
  localparam int RDBK_LO      = 5;
  localparam int MUXN_BIT     = 21;
  localparam int TCONV_BIT    = 16;
  localparam int TPROBE_BIT   = 15;
  localparam int TSEL_HI      = 14;
  localparam int TSEL_LO      = 5;
  localparam int INT_HI       = 28;
  localparam int INT_LO       = 17;
  localparam int SUB_UNIT_DIVIDE_VALUE_HI      = 16;
  localparam int SUB_UNIT_DIVIDE_VALUE_LO      = 5;
  localparam int CRST_BIT     = 5;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic latch_enable;
    logic serial_data;
    logic serial_clk;
  } rtxcrb_serial_type;

  typedef struct packed {
    logic [2:0]  aux_gain;
    logic        aux_div_one;
    logic        ref_cnt_pwr;
    logic        fb_cnt_pwr;
    logic        cal_second_tx;
    logic        cal_first_tx;
    logic        osc_pwr;
    logic        osc_cal;
    logic        conv_pwr;
    logic        second_transmit_channel_pwr;
    logic        first_transmit_channel_pwr;
    logic        mixer_drive_output_pwr;
    logic [7:0]  tx_level_code;
    logic [1:0]  conv_avg;
    logic [7:0]  conv_clk_div;
    logic [3:0]  mux_sel;
    logic        io_level_high;
    logic [5:0]  readback_sel;
    logic        mux_normal;
    logic        test_to_conv;
    logic        test_to_probe;
    logic [9:0]  test_sel;
    logic [11:0] int_divide;
    logic [11:0] sub_unit_divide_value_msb;
    logic        counter_reset_flag;
  } rtxcrb_ctrl_type;

  localparam rtxcrb_ctrl_type CTRL_RESET = '0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_LOAD  = 2'b11
  } rtxcrb_state_type;

endpackage

// file: verif/rtxcrb_host_model.sv
// Host side of the serial programming link: shifts words into the bank.
// Assumes a free-running 50 MHz clk_in; the pins are driven just after its edges.

`timescale 1ns/1ps

module rtxcrb_host_model (
  // Clock
  input  wire logic                          clk_in,
  // Serial programming pins
  output      rtxcrb_pkg::rtxcrb_serial_type serial_out
);
  import rtxcrb_pkg::*;

  // ----------------------------------------
  // Pin timing
  // ----------------------------------------
  // One more cycle than the bank's filter needs, so every level is seen
  localparam int HOLD = 4;

  // Pins idle low from time zero
  initial begin
    serial_out = '0;
  end

  // Waits n edges, then steps off the edge before touching any pin
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // ----------------------------------------
  // Word transfer
  // ----------------------------------------
  // Shifts the low n bits of w, top bit first, then strobes the latch
  task automatic send_bits(input logic [32:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_out.serial_data = w[i];
      wait_cycles(HOLD);
      serial_out.serial_clk = 1'b1;
      wait_cycles(HOLD);
      serial_out.serial_clk = 1'b0;
      wait_cycles(HOLD);
    end
    serial_out.latch_enable = 1'b1;
    wait_cycles(HOLD);
    serial_out.latch_enable = 1'b0;
    // Data hold has run out: do not leave the last bit standing
    serial_out.serial_data = ~serial_out.serial_data;
    wait_cycles(2 * HOLD);
  endtask
endmodule

// file: verif/radar_tx_control_register_bank_tb.sv
// Self-checking bench for the transmitter control register bank.
// Assumes the host model drives the pins and each word settles within its gap.

`timescale 1ns/1ps

module radar_tx_control_register_bank_tb;
  import rtxcrb_pkg::*;

  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic              clk_in;
  logic              rst_in;
  rtxcrb_serial_type serial;
  rtxcrb_ctrl_type   ctrl;
  rtxcrb_ctrl_type   exp_ctrl     = '0;
  logic [7:0]        exp_div_buf  = 8'h00;
  logic              conv_start;
  logic              word_taken;
  logic              word_refused;
  int                num_errors   = 0;
  int                cmp_count    = 0;
  int                seen_taken   = 0;
  int                seen_refused = 0;
  int                seen_conv    = 0;
  int                exp_taken    = 0;
  int                exp_refused  = 0;
  int                exp_conv     = 0;

  rtxcrb_bank #(.WORD_W(32)) dut_u (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .serial_in        (serial),
    .ctrl_out         (ctrl),
    .conv_start_out   (conv_start),
    .word_taken_out   (word_taken),
    .word_refused_out (word_refused)
  );

  rtxcrb_host_model host_u (
    .clk_in     (clk_in),
    .serial_out (serial)
  );

  // Clock and pulse counting; counting means no one-cycle pulse slips by
  initial clk_in = 1'b0;
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (word_taken === 1'b1) seen_taken++;
    if (word_refused === 1'b1) seen_refused++;
    if (conv_start === 1'b1) seen_conv++;
  end

  // ----------------------------------------
  // Compare and closing tasks
  // ----------------------------------------
  task automatic check_ctrl(input string what, input rtxcrb_ctrl_type exp);
    cmp_count++;
    if (ctrl !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, ctrl);
    end
  endtask

  task automatic check_count(input string what, input int exp, input int got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Expected state of the bank
  // ----------------------------------------
  task automatic expect_word(input logic [31:0] w);
    exp_taken++;
    case (w[4:0])
      5'h00: begin
        exp_ctrl.aux_gain = w[23:21];
        exp_ctrl.aux_div_one = w[20];
        exp_ctrl.ref_cnt_pwr = w[15];
        exp_ctrl.fb_cnt_pwr = w[14];
        exp_ctrl.cal_second_tx = w[12];
        exp_ctrl.cal_first_tx = w[11];
        exp_ctrl.osc_pwr = w[10];
        exp_ctrl.osc_cal = w[9];
        exp_ctrl.conv_pwr = w[8];
        exp_ctrl.second_transmit_channel_pwr = w[7];
        exp_ctrl.first_transmit_channel_pwr = w[6];
        exp_ctrl.mixer_drive_output_pwr = w[5];
      end
      5'h01: exp_ctrl.tx_level_code = w[12:5];
      5'h02: begin
        exp_ctrl.conv_avg = w[14:13];
        exp_div_buf = w[12:5];
        if (w[15]) exp_conv++;
      end
      5'h03: begin
        exp_ctrl.mux_sel = w[15:12];
        exp_ctrl.io_level_high = w[11];
        exp_ctrl.readback_sel = w[10:5];
      end
      5'h04: begin
        exp_ctrl.mux_normal = w[21];
        exp_ctrl.test_to_conv = w[16];
        exp_ctrl.test_to_probe = w[15];
        exp_ctrl.test_sel = w[14:5];
      end
      5'h05: begin
        exp_ctrl.int_divide = w[28:17];
        exp_ctrl.sub_unit_divide_value_msb = w[16:5];
        exp_ctrl.conv_clk_div = exp_div_buf;
      end
      5'h0B: exp_ctrl.counter_reset_flag = w[5];
      default: begin
        exp_taken--;
        exp_refused++;
      end
    endcase
  endtask

  // Sends n bits of w and judges outputs and pulse counts afterwards
  task automatic send_and_check(input logic [32:0] w, input int n);
    if (n >= 32) expect_word(w[31:0]);
    else exp_refused++;
    host_u.send_bits(w, n);
    check_ctrl("ctrl_out", exp_ctrl);
    check_count("words taken", exp_taken, seen_taken);
    check_count("words refused", exp_refused, seen_refused);
    check_count("conversion starts", exp_conv, seen_conv);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset_values();
    check_ctrl("ctrl_out after reset", '0);
    check_count("words taken after reset", 0, seen_taken);
  endtask

  // Complementary patterns set and clear every field except conv_clk_div, which takes the same buffered value both times; one transmit bit each
  task automatic s_every_register();
    logic [4:0] codes [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0B};
    foreach (codes[i]) begin
      send_and_check({1'b0, 32'hAAAA_AAA0 | 32'(codes[i])}, 32);
      send_and_check({1'b0, 32'h5555_5540 | 32'(codes[i])}, 32);
    end
  endtask

  task automatic s_buffered_divider();
    send_and_check({1'b0, 32'h0002_0642}, 32);
    send_and_check({1'b0, 32'h809F_E520}, 32);
    send_and_check({1'b0, 32'h0000_FFE2}, 32);
    send_and_check({1'b0, 32'h01E2_8005}, 32);
  endtask

  task automatic s_counter_reset();
    send_and_check({1'b0, 32'h0000_002B}, 32);
    send_and_check({1'b0, 32'h0000_000B}, 32);
  endtask

  // Unmapped codes must leave every control output alone
  task automatic s_refused_codes();
    for (int c = 6; c < 32; c++) begin
      if (c != 11) send_and_check({1'b0, 32'hFFFF_FF60 | 32'(c)}, 32);
    end
  endtask

  task automatic s_odd_lengths();
    send_and_check({2'b00, 31'h1234_5660}, 31);
    send_and_check({1'b1, 32'h0000_0160}, 33);
    send_and_check(33'h0_0000_0000, 0);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_in = 1'b1;
    repeat (20) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    @(posedge clk_in);
    #1;
    s_reset_values();
    s_every_register();
    s_buffered_divider();
    s_counter_reset();
    s_refused_codes();
    s_odd_lengths();
    stop_test();
  end

  // About 48 words of 400 cycles each; twice that is a hang
  initial begin
    repeat (40000) @(posedge clk_in);
    num_errors++;
    $display("Error run length expected finish seen timeout");
    stop_test();
  end
endmodule
